// ### verilog/rcu_consts.vh
// Constants for the readback CRC upset signalling block
`ifndef RCU_CONSTS_VH
`define RCU_CONSTS_VH
// ==========================================================
// Register map (word addresses on the plain register port)
`define RCU_ADDR_W          4
`define RCU_ADDR_CTRL       4'h0
`define RCU_ADDR_STATUS     4'h1
`define RCU_ADDR_IRQ_STAT   4'h2
`define RCU_ADDR_IRQ_MASK   4'h3
`define RCU_ADDR_GOLDEN     4'h4
`define RCU_ADDR_LAST       4'h5
`define RCU_ADDR_ROUNDS     4'h6
// ==========================================================
// Control register fields (options register one image)
`define RCU_CTRL_DET_EN     0
`define RCU_CTRL_PIN_SEL    1
`define RCU_CTRL_RST        2'h0
// ==========================================================
// Status register fields
`define RCU_ST_ERR          0
`define RCU_ST_GOLD_OK      1
`define RCU_ST_RUNNING      2
`define RCU_ST_PAUSED       3
`define RCU_ST_CFG_DONE     4
// ==========================================================
// Interrupt bits
`define RCU_IRQ_W           3
`define RCU_IRQ_UPSET       0
`define RCU_IRQ_GOLD        1
`define RCU_IRQ_RELEASE     2
`define RCU_IRQ_RST         3'h0
// ==========================================================
// Engine states
`define RCU_S_IDLE          2'h0
`define RCU_S_READ          2'h1
`define RCU_S_CMP           2'h2
// ==========================================================
// Engine details
`define RCU_CRC_POLY        8'h07
`define RCU_SYNC_N          3
`define RCU_PIN_DONE        0
`define RCU_PIN_ACC         1
`define RCU_PIN_CFGL        2
`endif

// ### verilog/rcu_readback_crc.v
// Readback CRC upset detector with status pin and flag signalling
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Notes on behaviour
// - During configuration the status pin keeps its ordinary configuration role.
// - After configuration, enabled and pin selected: pin becomes upset status.
// - Upset declared when readback CRC differs from the reference CRC.
// - Upset drives mismatch flag high and, if pin used, pin low.
// - Enable setting runs background detection; disable means no detection.
// - Primitive-only selection leaves the pin unused for upset reporting.
// - Pin-and-primitive selection reports on both pin and flag.
// - With pin disabled, error still shows on the mismatch flag.
// - Check CRC comes from periodic readback of configuration cells.
// - Pin selection is one bit in options register one.
// - Pin reserved means no user buffer drives it.
// - First completed round latched as reference; later rounds compared.
// - Flag holds until next comparison and while no new reference.
// - Config access pauses checking and clears flag; resumes after.
// - Interface release command resets checker and clears all errors.
`include "rcu_consts.vh"
// ==========================================================
// Limitations: the CRC uses a short toy polynomial, so it only tells
// that a round differs from the reference, not which cell moved.
// frame_count_in must be at least one and steady while a round runs.
// The release pulse is sampled directly, so its source must share
// clk_in; a release from another clock would need a handshake.

module rcu_readback_crc #(
  parameter CRC_W    = 32,
  parameter WORD_W   = 32,
  parameter FRAMES_W = 16
) (
  input  wire                  clk_in,           // System clock
  input  wire                  rst_in,           // Async reset, high
  // Register port
  input  wire [`RCU_ADDR_W-1:0] reg_addr_in,     // Word address
  input  wire [31:0]           reg_wdata_in,     // Write data
  input  wire                  reg_wr_in,        // Write strobe
  input  wire                  reg_rd_in,        // Read strobe
  output reg  [31:0]           reg_rdata_out,    // Read data, next cycle
  output reg                   irq_out,          // Level interrupt
  // Configuration logic side
  input  wire                  cfg_done_in,      // Configuration finished
  input  wire                  cfg_access_in,    // Port access in progress
  input  wire                  release_cmd_in,   // Interface release pulse
  input  wire                  init_cfg_low_in,  // Config-role pin pull low
  input  wire [FRAMES_W-1:0]   frame_count_in,   // Words per round
  output reg                   rb_req_out,       // Readback word request
  input  wire                  rb_valid_in,      // Readback word valid
  input  wire [WORD_W-1:0]     rb_word_in,       // Readback word
  // User side
  output reg                   upset_flag_out,   // Mismatch flag to user
  input  wire                  user_buf_oe_in,   // User buffer wants pin
  input  wire                  user_buf_o_in,    // User buffer value
  output reg                   init_o_out,       // Status pin output value
  output reg                   init_oe_out       // Status pin output enable
);

  // ==========================================================
  // CRC step, one readback word folded in
  // Bit 0 of each word goes in first
  function [CRC_W-1:0] crc_step;
    input [CRC_W-1:0]  c;
    input [WORD_W-1:0] w;
    integer            i;
    reg   [CRC_W-1:0]  t;
    begin
      t = c;
      for (i = 0; i < WORD_W; i = i + 1) begin
        t = {t[CRC_W-2:0], 1'b0} ^
            ((t[CRC_W-1] ^ w[i]) ? {{(CRC_W-8){1'b0}}, `RCU_CRC_POLY} :
             {CRC_W{1'b0}});
      end
      crc_step = t;
    end
  endfunction

  // ==========================================================
  // Address decode, shared by the write strobes
  function addr_hit;
    input [`RCU_ADDR_W-1:0] a;
    input [`RCU_ADDR_W-1:0] want;
    begin
      addr_hit = (a == want);
    end
  endfunction

  // ==========================================================
  // Registers
  reg [1:0]             ctrl_q;
  reg [`RCU_IRQ_W-1:0]  irq_stat_q;
  reg [`RCU_IRQ_W-1:0]  irq_mask_q;
  reg [1:0]             state_q;
  reg [CRC_W-1:0]       crc_q;
  reg [CRC_W-1:0]       gold_q;
  reg [CRC_W-1:0]       last_q;
  reg                   gold_ok_q;
  reg                   err_q;
  reg [FRAMES_W-1:0]    cnt_q;
  // Round counter wraps; it is only a sign of life for software
  reg [15:0]            rounds_q;
  reg [31:0]            status_word;
  wire [`RCU_SYNC_N-1:0] pin_q;
  wire                  done_q = pin_q[`RCU_PIN_DONE];
  wire                  acc_q  = pin_q[`RCU_PIN_ACC];
  wire                  cfgl_q = pin_q[`RCU_PIN_CFGL];

  wire det_en  = ctrl_q[`RCU_CTRL_DET_EN];
  wire pin_sel = ctrl_q[`RCU_CTRL_PIN_SEL];
  wire run_ok  = det_en && done_q && !acc_q;
  wire wr_ctrl = reg_wr_in && addr_hit(reg_addr_in, `RCU_ADDR_CTRL);
  wire wr_stat = reg_wr_in && addr_hit(reg_addr_in, `RCU_ADDR_IRQ_STAT);
  wire wr_mask = reg_wr_in && addr_hit(reg_addr_in, `RCU_ADDR_IRQ_MASK);

  // ==========================================================
  // Pin synchronisers: a change counts once stages two and three agree.
  // Stage one may go metastable, so only stage two ever reads it.
  // One copy per pin; all three share the same settling rule.
  wire [`RCU_SYNC_N-1:0] pin_raw = {init_cfg_low_in, cfg_access_in,
                                    cfg_done_in};
  genvar g;
  generate
    for (g = 0; g < `RCU_SYNC_N; g = g + 1) begin : g_sync
      reg [2:0] stg_q;
      reg       val_q;
      always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          stg_q <= 3'h0;
          val_q <= 1'b0;
        end else begin
          stg_q <= {stg_q[1:0], pin_raw[g]};
          if (stg_q[1] == stg_q[2])
            val_q <= stg_q[2];
        end
      end
      assign pin_q[g] = val_q;
    end
  endgenerate

  // ==========================================================
  // Readback engine
  wire last_word = rb_valid_in && (cnt_q + 1'b1 >= frame_count_in);
  wire [CRC_W-1:0] crc_nx = crc_step(crc_q, rb_word_in);
  wire cmp_evt  = (state_q == `RCU_S_CMP);
  wire mismatch = cmp_evt && gold_ok_q && (crc_q != gold_q);
  wire gold_evt = cmp_evt && !gold_ok_q;

  // Release wins over everything but reset: it drops the reference as well, while
  // an access or a disable keeps the reference, abandons the round and drops the flag.
  // A round cut short restarts from its first word, never resumes.

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q    <= `RCU_S_IDLE;
      crc_q      <= {CRC_W{1'b0}};
      gold_q     <= {CRC_W{1'b0}};
      last_q     <= {CRC_W{1'b0}};
      gold_ok_q  <= 1'b0;
      err_q      <= 1'b0;
      cnt_q      <= {FRAMES_W{1'b0}};
      rounds_q   <= 16'h0;
      rb_req_out <= 1'b0;
    end else if (release_cmd_in) begin
      // Fresh reference taken after every release
      state_q    <= `RCU_S_IDLE;
      gold_ok_q  <= 1'b0;
      err_q      <= 1'b0;
      cnt_q      <= {FRAMES_W{1'b0}};
      rb_req_out <= 1'b0;
    end else if (!run_ok) begin
      // Access or disable: abandon round, drop flag, keep reference
      state_q    <= `RCU_S_IDLE;
      err_q      <= 1'b0;
      cnt_q      <= {FRAMES_W{1'b0}};
      rb_req_out <= 1'b0;
    end else begin
      case (state_q)
        `RCU_S_IDLE: begin
          // Arm a fresh round with the CRC seeded all ones
          crc_q      <= {CRC_W{1'b1}};
          cnt_q      <= {FRAMES_W{1'b0}};
          rb_req_out <= 1'b1;
          state_q    <= `RCU_S_READ;
        end
        `RCU_S_READ: begin
          // Stalls on the readback side simply stretch the round
          if (rb_valid_in) begin
            crc_q <= crc_nx;
            cnt_q <= cnt_q + 1'b1;
          end
          if (last_word) begin
            rb_req_out <= 1'b0;
            state_q    <= `RCU_S_CMP;
          end
        end
        `RCU_S_CMP: begin
          // One cycle: the first round becomes the reference
          last_q   <= crc_q;
          rounds_q <= rounds_q + 16'h1;
          if (!gold_ok_q) begin
            gold_q    <= crc_q;
            gold_ok_q <= 1'b1;
          end else begin
            err_q <= mismatch;
          end
          state_q <= `RCU_S_IDLE;
        end
        default: state_q <= `RCU_S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Status pin and mismatch flag
  // The block itself only ever pulls the pin low, so while it is reserved the enable
  // alone carries the upset; the user buffer is locked out of it then.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      upset_flag_out <= 1'b0;
      init_o_out     <= 1'b0;
      init_oe_out    <= 1'b0;
    end else begin
      upset_flag_out <= err_q;
      if (!done_q) begin
        init_o_out  <= 1'b0;
        init_oe_out <= cfgl_q;
      end else if (det_en && pin_sel) begin
        init_o_out  <= 1'b0;
        init_oe_out <= err_q;
      end else begin
        init_o_out  <= user_buf_o_in;
        init_oe_out <= user_buf_oe_in;
      end
    end
  end

  // ==========================================================
  // Control and interrupts
  // Events go straight into the sticky bits; irq_out lags them a cycle
  wire [`RCU_IRQ_W-1:0] irq_evt = {release_cmd_in, gold_evt, mismatch};

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q     <= `RCU_CTRL_RST;
      irq_stat_q <= `RCU_IRQ_RST;
      irq_mask_q <= `RCU_IRQ_RST;
      irq_out    <= 1'b0;
    end else begin
      if (wr_ctrl)
        ctrl_q <= reg_wdata_in[1:0];
      if (wr_mask)
        irq_mask_q <= reg_wdata_in[`RCU_IRQ_W-1:0];
      // Set wins over a clear in the same cycle
      irq_stat_q <= (irq_stat_q &
                     ~(wr_stat ? reg_wdata_in[`RCU_IRQ_W-1:0] :
                       {`RCU_IRQ_W{1'b0}})) | irq_evt;
      irq_out <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ==========================================================
  // Status word, assembled field by field
  always @* begin
    status_word                   = 32'h0;
    status_word[`RCU_ST_ERR]      = err_q;
    status_word[`RCU_ST_GOLD_OK]  = gold_ok_q;
    status_word[`RCU_ST_RUNNING]  = run_ok;
    status_word[`RCU_ST_PAUSED]   = acc_q;
    status_word[`RCU_ST_CFG_DONE] = done_q;
  end

  // ==========================================================
  // Read port: data stands one cycle and is zero otherwise, so a
  // late sample by the master never shows stale register contents
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h0;
    end else begin
      reg_rdata_out <= 32'h0;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `RCU_ADDR_CTRL:     reg_rdata_out <= {30'h0, ctrl_q};
          `RCU_ADDR_STATUS:   reg_rdata_out <= status_word;
          `RCU_ADDR_IRQ_STAT: reg_rdata_out <= {29'h0, irq_stat_q};
          `RCU_ADDR_IRQ_MASK: reg_rdata_out <= {29'h0, irq_mask_q};
          `RCU_ADDR_GOLDEN:   reg_rdata_out <= gold_q[31:0];
          `RCU_ADDR_LAST:     reg_rdata_out <= last_q[31:0];
          `RCU_ADDR_ROUNDS:   reg_rdata_out <= {16'h0, rounds_q};
          default:            reg_rdata_out <= 32'h0;
        endcase
      end
    end
  end

endmodule // rcu_readback_crc
`default_nettype wire

// ### bench/rcu_readback_crc_properties.sv
// Assertion checker for the readback CRC upset block
`timescale 1ns/100ps
`default_nettype none
module rcu_chk #(parameter FRAMES_W = 16) (
  input wire logic                clk_in, rst_in, reg_rd_in,
  input wire logic [31:0]         reg_rdata_out,
  input wire logic                cfg_done_in, cfg_access_in,
  input wire logic                release_cmd_in, init_cfg_low_in,
  input wire logic [FRAMES_W-1:0] frame_count_in,
  input wire logic                rb_req_out, rb_valid_in,
  input wire logic                upset_flag_out, user_buf_oe_in,
  input wire logic                user_buf_o_in, init_o_out, init_oe_out
);
  logic [FRAMES_W-1:0] wcnt_q;
  logic [2:0]          since_q;
  wire logic           last_w = rb_req_out && rb_valid_in &&
                                wcnt_q == frame_count_in - 1'b1;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ==========
  // Round tracking
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) wcnt_q <= '0;
    else if (!rb_req_out) wcnt_q <= '0;
    else if (rb_valid_in) wcnt_q <= wcnt_q + 1'b1;
  end
  // Saturates so a stale round end cannot excuse a late flag
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) since_q <= 3'h7;
    else if (last_w) since_q <= 3'h0;
    else if (since_q != 3'h7) since_q <= since_q + 3'h1;
  end
  sequence s_last_word; last_w; endsequence
  sequence s_cfg_quiet;
    (!cfg_done_in && $stable(init_cfg_low_in)) [*6];
  endsequence
  a_rdata_one_cycle: assert property (
    !$past(reg_rd_in) |-> reg_rdata_out == 32'h0) else $error("stray data");
  a_cfg_pin_role: assert property (s_cfg_quiet |->
    init_oe_out == init_cfg_low_in && !init_o_out && !rb_req_out)
    else $error("pin left config role early");
  a_pin_user_only: assert property (init_oe_out && init_o_out |->
    $past(user_buf_oe_in) && $past(user_buf_o_in)) else $error("pin high");
  a_round_words: assert property (
    rb_req_out |-> wcnt_q < frame_count_in) else $error("round too long");
  a_round_end: assert property (s_last_word |=> !rb_req_out)
    else $error("request held after last word");
  a_flag_at_cmp: assert property ($rose(upset_flag_out) |->
    since_q <= 3'h4) else $error("flag rose outside a comparison");
  a_release_clear: assert property (
    release_cmd_in |-> ##[1:2] !upset_flag_out) else $error("flag kept");
  a_access_pause: assert property (cfg_access_in [*8] |->
    !upset_flag_out && !rb_req_out) else $error("checking during access");
endmodule // rcu_chk
bind rcu_readback_crc rcu_chk #(.FRAMES_W(FRAMES_W)) u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .cfg_done_in(cfg_done_in),
  .cfg_access_in(cfg_access_in), .release_cmd_in(release_cmd_in),
  .init_cfg_low_in(init_cfg_low_in), .frame_count_in(frame_count_in),
  .rb_req_out(rb_req_out), .rb_valid_in(rb_valid_in),
  .upset_flag_out(upset_flag_out), .user_buf_oe_in(user_buf_oe_in),
  .user_buf_o_in(user_buf_o_in), .init_o_out(init_o_out),
  .init_oe_out(init_oe_out));
`default_nettype wire

// ### bench/rcu_cfg_model.sv
// Configuration memory readback source model
`timescale 1ns/100ps
`default_nettype none
module rcu_cfg_model (
  input  wire logic        clk_in,       // Clock
  input  wire logic        rst_in,       // Reset, high
  input  wire logic        rb_req_in,    // Engine wants words
  input  wire logic        stall_in,     // Hold off this cycle
  input  wire logic        flip_in,      // Upset the cells
  output var  logic        rb_valid_out, // Word valid
  output var  logic [31:0] rb_word_out   // Word
);
  // Same word every frame, so a restarted round cannot misalign
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rb_valid_out <= 1'b0;
      rb_word_out  <= 32'h0;
    end else if (rb_req_in && !stall_in) begin
      rb_valid_out <= 1'b1;
      rb_word_out  <= flip_in ? 32'ha5c361e8 : 32'h5a3c9e17;
    end else begin
      rb_valid_out <= 1'b0;
      rb_word_out  <= ~rb_word_out; // Stale word inverts every idle cycle
    end
  end
endmodule // rcu_cfg_model
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the readback CRC upset block
`timescale 1ns/100ps
`default_nettype none
`include "rcu_consts.vh"
module tb;
  localparam logic [3:0] CT = `RCU_ADDR_CTRL, ST = `RCU_ADDR_STATUS;
  localparam logic [3:0] RN = `RCU_ADDR_ROUNDS, IM = `RCU_ADDR_IRQ_MASK;
  logic        clk_in = 1'b0, rst_in = 1'b1, wr = 1'b0, rd = 1'b0;
  logic        done = 1'b0, acc = 1'b0, rel = 1'b0, low = 1'b0;
  logic        boe = 1'b0, bo = 1'b0, stall = 1'b0, flip = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata_q, r0;
  wire logic [31:0] rdata, word;
  wire logic   irq, req, valid, flag, po, poe;
  integer      seed = 32'h2e2110da, n_fail = 0, num_checks = 0, cyc = 0;
  always #5 clk_in = ~clk_in;
  rcu_readback_crc u_dut (.clk_in(clk_in), .rst_in(rst_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .irq_out(irq),
    .cfg_done_in(done), .cfg_access_in(acc), .release_cmd_in(rel),
    .init_cfg_low_in(low), .frame_count_in(16'h0004), .rb_req_out(req),
    .rb_valid_in(valid), .rb_word_in(word), .upset_flag_out(flag),
    .user_buf_oe_in(boe), .user_buf_o_in(bo), .init_o_out(po),
    .init_oe_out(poe));
  rcu_cfg_model u_mem (.clk_in(clk_in), .rst_in(rst_in), .rb_req_in(req),
    .stall_in(stall), .flip_in(flip), .rb_valid_out(valid),
    .rb_word_out(word));
  // ==========
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk_in);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk_in);
    rd <= 1'b0;
    #1 rdata_q = rdata;
  endtask
  // Bounded poll; the caller judges the last value read
  task automatic poll(input logic [3:0] a, input int b, input logic v);
    rd_reg(a);
    for (int i = 0; i < 100 && rdata_q[b] !== v; i++) rd_reg(a);
  endtask
  // Random stalls on the readback side, and the hang limit
  always @(posedge clk_in) begin
    stall <= ($random(seed) % 4) == 0;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      finish_test;
    end
  end
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    rd_reg(CT);
    chk("ctrl reset", rdata_q, `RCU_CTRL_RST);
    rd_reg(4'hf);
    chk("unmapped", rdata_q, 32'h0);
    @(posedge clk_in) {low, flip} <= 2'b11;
    wr_reg(CT, 32'h3);
    wr_reg(IM, 32'h7);
    gap(40);
    chk("cfg role", {poe, po, req}, 3'b100);
    rd_reg(CT);
    chk("ctrl bits", rdata_q, 32'h3);
    $display("test config role done");
    @(posedge clk_in) {low, flip, done, boe, bo} <= 5'b00111;
    poll(ST, `RCU_ST_GOLD_OK, 1'b1);
    chk("golden", rdata_q[`RCU_ST_GOLD_OK], 1'b1);
    wr_reg(`RCU_ADDR_IRQ_STAT, 32'h7);
    rd_reg(RN);
    r0 = rdata_q;
    gap(100);
    chk("pin held", {flag, poe}, 2'b00);
    rd_reg(RN);
    chk("rounds repeat", rdata_q > r0, 1'b1);
    @(posedge clk_in) flip <= 1'b1;
    poll(ST, `RCU_ST_ERR, 1'b1);
    gap(2);
    chk("upset", {flag, poe, po, irq}, 4'b1101);
    wr_reg(IM, 32'h0);
    gap(2);
    chk("irq masked", irq, 1'b0);
    $display("test upset done");
    @(posedge clk_in) {acc, flip} <= 2'b10;
    gap(10);
    chk("access clears", flag, 1'b0);
    @(posedge clk_in) acc <= 1'b0;
    gap(150);
    rd_reg(ST);
    chk("resumed", {flag, rdata_q[`RCU_ST_GOLD_OK]}, 2'b01);
    wr_reg(CT, 32'h1);
    @(posedge clk_in) flip <= 1'b1;
    poll(ST, `RCU_ST_ERR, 1'b1);
    gap(2);
    chk("flag only", {flag, poe, po}, 3'b111);
    @(posedge clk_in) rel <= 1'b1;
    @(posedge clk_in) rel <= 1'b0;
    rd_reg(ST);
    chk("release", {flag, rdata_q[`RCU_ST_GOLD_OK]}, 2'b00);
    rd_reg(`RCU_ADDR_IRQ_STAT);
    chk("release irq", rdata_q[`RCU_IRQ_RELEASE], 1'b1);
    poll(ST, `RCU_ST_GOLD_OK, 1'b1);
    gap(100);
    chk("new golden", flag, 1'b0);
    $display("test release done");
    @(posedge clk_in) flip <= 1'b0;
    poll(ST, `RCU_ST_ERR, 1'b1);
    wr_reg(CT, 32'h0);
    rd_reg(RN);
    r0 = rdata_q;
    wr_reg(`RCU_ADDR_IRQ_STAT, 32'h7);
    wr_reg(IM, 32'h7);
    gap(100);
    rd_reg(RN);
    chk("disabled", {flag, irq, rdata_q}, {2'b00, r0});
    $display("test disable done");
    finish_test;
  end
endmodule // tb
`default_nettype wire
